/* File: hw/ssp_top.sv */
/*
  Serial slave register port: I2C, SMBus and 3/4-wire SPI on shared pins,
  forming 16-bit register addresses and driving a byte register bus.
  Assumes a register file answering reg_rd_out with data on the next clock,
  and configuration inputs that come from logic on clk_in.
*/
// Function
// - I2C two-byte offset gives page and register
// - I2C write and repeated-start read framing
// - configuration changes apply only between transactions
// - SPI four-wire default, three-wire by bit
// - data output driven only for read data
// - SPI address A14..A0, then data, auto-increment
// - SPI one-byte: page supplies upper nine bits
// - offset FD writes the page register; here only in one-byte and SMBus modes, never with two-byte offsets
// - SPI two-byte: fifteen bits plus page bit
// - SPI sampling edge chosen by configuration
// - SPI read launch edge chosen by configuration
// - pointer advances after every data byte
// - SMBus slave runs at 100k, 400k, 1M
// - SMBus uses seven-bit offsets, ignores size
// - bus address from configuration, default 09
// - SMBus address is page plus seven bits
// - SMBus offset top bit selects block mode
// - block byte count first; count defaults 08
// - protocol select field, I2C after reset
// - offset size bit, one-byte after reset
`default_nettype none

module ssp_top import ssp_pkg::*; (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        serial_clk_in,
  input  wire logic        data_or_select_pin_in,
  output logic             data_or_select_pin_out,
  output logic             data_or_select_pin_oe_out,
  input  wire logic        serial_in_line_in,
  output logic             serial_in_line_out,
  output logic             serial_in_line_oe_out,
  output logic             serial_out_line_out,
  output logic             serial_out_line_oe_out,
  input  wire logic [1:0]  cfg_proto_in,
  input  wire logic        cfg_addr_size_in,
  input  wire logic        cfg_bidir_line_mode_in,
  input  wire logic        cfg_clk_sel_in,
  input  wire logic        cfg_del_out_in,
  input  wire logic [6:0]  cfg_dev_addr_in,
  output logic      [15:0] reg_addr_out,
  output logic      [7:0]  reg_wdata_out,
  output logic             reg_wr_out,
  output logic             reg_rd_out,
  input  wire logic [7:0]  reg_rdata_in,
  output logic      [8:0]  page_out,
  output logic      [7:0]  block_count_out,
  output logic             busy_out
);

  // ==========================================================================
  // declarations
  logic [1:0]  proto_r;
  logic        asz_r, bidir_r, csel_r, dly_r, spi_en_r;
  logic [6:0]  dev_r;
  logic        scl_s, sda_s, tog_c, scl_q, sda_q, tog_q;
  logic        scl_rise, scl_fall, start_c, stop_c, i2c_en, smb, ok_c, busy_c;
  ssp_i2c_st_e st_r;
  ssp_phase_e  ph_r;
  logic [3:0]  bcnt_r;
  logic [7:0]  sh_r, offh_r, i2c_wd_r, rd_hold_r;
  logic        rw_r, blk_r, cntf_r, i2c_set_r, i2c_rd_r, i2c_wr_r;
  logic [15:0] i2c_addr_r, spi_addr_r, ptr_r, eff;
  logic        spi_set_r, spi_rd_r, spi_wr_r, rq_set, rq_rd, rq_wr, rd_cap_r, page_hit;
  logic [7:0]  spi_wd_r, rq_wd;
  logic [15:0] rq_addr;
  logic [8:0]  page_r;
  logic        spi_clk, lau_clk, spi_arst;
  logic [4:0]  hcnt_s, hdr_len;
  logic [14:0] hsh_s, hold_a_s;
  logic        hdr_s, rw_s, evh_s, tog_s, nbit;
  logic [2:0]  dcnt_s;
  logic [6:0]  dsh_s, txl_s;
  logic [7:0]  hold_d_s;

  // ==========================================================================
  // pin synchronisers; 100 MHz oversampling covers every SMBus rate
  ssp_sync #(.W(3)) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   ({serial_clk_in, data_or_select_pin_in, tog_s}),
    .q_out  ({scl_s, sda_s, tog_c})
  );

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_q <= 1'b0;
      sda_q <= 1'b0;
      tog_q <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      tog_q <= tog_c;
    end
  end

  assign i2c_en   = (proto_r != PROTO_SPI);
  assign smb      = (proto_r == PROTO_SMB);
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c  = i2c_en & scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c   = i2c_en & scl_s & scl_q & ~sda_q & sda_s;
  assign ok_c     = i2c_en & ~start_c & ~stop_c;
  assign busy_c   = (st_r != I2C_IDLE) | (spi_en_r & ~sda_s);

  // ==========================================================================
  // configuration, latched only while no transaction is open
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      proto_r  <= PROTO_RST;
      asz_r    <= ASZ_RST;
      bidir_r  <= BIDIR_RST;
      csel_r   <= CLK_SEL_RST;
      dly_r    <= DEL_OUT_RST;
      dev_r    <= DEV_ADDR_RST;
      spi_en_r <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      busy_out <= busy_c;
      if (!busy_c) begin
        proto_r  <= cfg_proto_in;
        asz_r    <= cfg_addr_size_in;
        bidir_r  <= cfg_bidir_line_mode_in;
        csel_r   <= cfg_clk_sel_in;
        dly_r    <= cfg_del_out_in;
        dev_r    <= cfg_dev_addr_in;
        spi_en_r <= (cfg_proto_in == PROTO_SPI);
      end
    end
  end

  // ==========================================================================
  // I2C / SMBus byte engine
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= I2C_IDLE;
      ph_r <= PH_DEV;
      bcnt_r <= 4'h0;
      sh_r <= 8'h00;
      offh_r <= 8'h00;
      rw_r <= 1'b0;
      blk_r <= 1'b0;
      cntf_r <= 1'b0;
      block_count_out <= BLK_CNT_RST;
      data_or_select_pin_oe_out <= 1'b0;
      i2c_set_r <= 1'b0;
      i2c_rd_r <= 1'b0;
      i2c_wr_r <= 1'b0;
      i2c_addr_r <= 16'h0000;
      i2c_wd_r <= 8'h00;
    end else begin
      i2c_set_r <= 1'b0;
      i2c_rd_r  <= 1'b0;
      i2c_wr_r  <= 1'b0;
      if (!i2c_en || stop_c) begin
        st_r <= I2C_IDLE;
        blk_r <= 1'b0;
        data_or_select_pin_oe_out <= 1'b0;
      end else if (start_c) begin
        st_r <= I2C_RX;
        ph_r <= PH_DEV;
        bcnt_r <= 4'h0;
        data_or_select_pin_oe_out <= 1'b0;
      end else begin
        case (st_r)
          I2C_RX: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_s};
              bcnt_r <= bcnt_r + 4'h1;
            end else if (scl_fall && bcnt_r == BITS_PER_BYTE) begin
              if (ph_r == PH_DEV && sh_r[7:1] != dev_r) begin
                st_r <= I2C_IDLE;
              end else begin
                st_r <= I2C_ACK;
                data_or_select_pin_oe_out <= 1'b1;
                case (ph_r)
                  PH_DEV: begin
                    rw_r <= sh_r[0];
                    cntf_r <= sh_r[0] & blk_r;
                    i2c_rd_r <= sh_r[0] & ~blk_r;
                    if (sh_r[0]) begin
                      ph_r <= PH_DATA;
                    end else if (!smb && asz_r == ASZ_2B) begin
                      ph_r <= PH_OFFH;
                    end else begin
                      ph_r <= PH_OFFL;
                    end
                  end
                  PH_OFFH: begin
                    offh_r <= sh_r;
                    ph_r <= PH_OFFL;
                  end
                  PH_OFFL: begin
                    i2c_set_r <= 1'b1;
                    blk_r <= smb & ~sh_r[SMB_BLK_BIT];
                    ph_r <= (smb && !sh_r[SMB_BLK_BIT]) ? PH_CNT : PH_DATA;
                    if (smb) begin
                      i2c_addr_r <= {page_r, sh_r[6:0]};
                    end else if (asz_r == ASZ_2B) begin
                      i2c_addr_r <= {offh_r, sh_r};
                    end else begin
                      i2c_addr_r <= {page_r[7:0], sh_r};
                    end
                  end
                  PH_CNT: begin
                    block_count_out <= sh_r;
                    ph_r <= PH_DATA;
                  end
                  default: begin
                    i2c_wr_r <= 1'b1;
                    i2c_wd_r <= sh_r;
                  end
                endcase
              end
            end
          end
          I2C_ACK: begin
            if (scl_fall) begin
              if (rw_r) begin
                st_r <= I2C_TX;
                sh_r <= cntf_r ? block_count_out : rd_hold_r;
                data_or_select_pin_oe_out <= cntf_r ? ~block_count_out[7] : ~rd_hold_r[7];
                cntf_r <= 1'b0;
                bcnt_r <= 4'h1;
              end else begin
                st_r <= I2C_RX;
                bcnt_r <= 4'h0;
                data_or_select_pin_oe_out <= 1'b0;
              end
            end
          end
          I2C_TX: begin
            if (scl_fall) begin
              if (bcnt_r == BITS_PER_BYTE) begin
                st_r <= I2C_MACK;
                data_or_select_pin_oe_out <= 1'b0;
              end else begin
                data_or_select_pin_oe_out <= ~sh_r[6];
                sh_r <= {sh_r[6:0], 1'b0};
                bcnt_r <= bcnt_r + 4'h1;
              end
            end
          end
          I2C_MACK: begin
            if (scl_rise) begin
              // master nack ends the read; an ack fetches the next byte
              st_r <= sda_s ? I2C_IDLE : I2C_ACK;
              i2c_rd_r <= ~sda_s;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // SPI events arriving from the link domain
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      spi_set_r <= 1'b0;
      spi_rd_r <= 1'b0;
      spi_wr_r <= 1'b0;
      spi_addr_r <= 16'h0000;
      spi_wd_r <= 8'h00;
    end else begin
      spi_set_r <= 1'b0;
      spi_rd_r <= 1'b0;
      spi_wr_r <= 1'b0;
      if (spi_en_r && tog_c != tog_q) begin
        if (evh_s) begin
          spi_set_r <= 1'b1;
          spi_rd_r <= rw_s;
          if (asz_r == ASZ_2B) begin
            spi_addr_r <= {page_r[8], hold_a_s};
          end else begin
            spi_addr_r <= {page_r, hold_a_s[6:0]};
          end
        end else if (rw_s) begin
          spi_rd_r <= 1'b1;
        end else begin
          spi_wr_r <= 1'b1;
          spi_wd_r <= hold_d_s;
        end
      end
    end
  end

  // ==========================================================================
  // shared register access and address pointer
  assign rq_set   = i2c_set_r | spi_set_r;
  assign rq_rd    = i2c_rd_r | spi_rd_r;
  assign rq_wr    = i2c_wr_r | spi_wr_r;
  assign rq_wd    = spi_en_r ? spi_wd_r : i2c_wd_r;
  assign rq_addr  = spi_en_r ? spi_addr_r : i2c_addr_r;
  assign eff      = rq_set ? rq_addr : ptr_r;
  assign page_hit = (smb || asz_r == ASZ_1B) && eff[6:0] == PAGE_OFF[6:0]
                    && (proto_r != PROTO_I2C || eff[7] == PAGE_OFF[7]);
  assign page_out = page_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ptr_r <= 16'h0000;
      page_r <= PAGE_RST;
      reg_addr_out <= 16'h0000;
      reg_wdata_out <= 8'h00;
      reg_wr_out <= 1'b0;
      reg_rd_out <= 1'b0;
      rd_cap_r <= 1'b0;
      rd_hold_r <= 8'h00;
    end else begin
      reg_wr_out <= 1'b0;
      reg_rd_out <= 1'b0;
      rd_cap_r <= reg_rd_out;
      if (rd_cap_r) begin
        rd_hold_r <= reg_rdata_in;
      end
      if (rq_wr) begin
        if (page_hit) begin
          page_r <= {1'b0, rq_wd};
        end else begin
          reg_wr_out <= 1'b1;
          reg_addr_out <= eff;
          reg_wdata_out <= rq_wd;
        end
        ptr_r <= eff + 16'h0001;
      end else if (rq_rd) begin
        reg_rd_out <= 1'b1;
        reg_addr_out <= eff;
        ptr_r <= eff + 16'h0001;
      end else if (rq_set) begin
        ptr_r <= rq_addr;
      end
    end
  end

  // ==========================================================================
  // SPI link domain; clock inversion is safe since settings move only idle
  assign spi_clk  = serial_clk_in ^ csel_r;
  assign lau_clk  = spi_clk ^ ~dly_r;
  assign spi_arst = data_or_select_pin_in | ~spi_en_r;
  assign hdr_len  = (asz_r == ASZ_2B) ? SPI_HDR_2B : SPI_HDR_1B;

  always_ff @(posedge spi_clk or posedge spi_arst) begin
    if (spi_arst) begin
      hcnt_s <= 5'h00;
      hsh_s <= 15'h0000;
      hdr_s <= 1'b0;
      dcnt_s <= DBIT_FIRST;
      dsh_s <= 7'h00;
    end else if (!hdr_s) begin
      hsh_s <= {hsh_s[13:0], serial_in_line_in};
      hcnt_s <= hcnt_s + 5'h01;
      hdr_s <= (hcnt_s == hdr_len - 5'h01);
    end else begin
      dcnt_s <= dcnt_s + 3'h1;
      dsh_s <= {dsh_s[5:0], serial_in_line_in};
    end
  end

  // holding side is not cleared by select, so the event toggle never slips
  always_ff @(posedge spi_clk or posedge rst_in) begin
    if (rst_in) begin
      rw_s <= 1'b0;
      evh_s <= 1'b0;
      tog_s <= 1'b0;
      hold_a_s <= 15'h0000;
      hold_d_s <= 8'h00;
    end else if (!hdr_s) begin
      if (hcnt_s == 5'h00) begin
        rw_s <= serial_in_line_in;
      end
      if (!spi_arst && hcnt_s == hdr_len - 5'h01) begin
        hold_a_s <= {hsh_s[13:0], serial_in_line_in};
        evh_s <= 1'b1;
        tog_s <= ~tog_s;
      end
    end else if (rw_s ? dcnt_s == DBIT_FIRST : dcnt_s == DBIT_LAST) begin
      hold_d_s <= {dsh_s, serial_in_line_in};
      evh_s <= 1'b0;
      tog_s <= ~tog_s;
    end
  end

  // read launch; the first byte needs the register fetch done before its
  // first launch edge, later bytes are fetched one byte ahead
  assign nbit = (dcnt_s == DBIT_FIRST) ? rd_hold_r[7] : txl_s[6];

  always_ff @(posedge lau_clk or posedge spi_arst) begin
    if (spi_arst) begin
      txl_s <= 7'h00;
      serial_out_line_out <= 1'b0;
      serial_out_line_oe_out <= 1'b0;
      serial_in_line_out <= 1'b0;
      serial_in_line_oe_out <= 1'b0;
    end else if (hdr_s && rw_s) begin
      txl_s <= (dcnt_s == DBIT_FIRST) ? rd_hold_r[6:0] : {txl_s[5:0], 1'b0};
      serial_out_line_out <= nbit;
      serial_in_line_out <= nbit;
      serial_out_line_oe_out <= ~bidir_r;
      serial_in_line_oe_out <= bidir_r;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_or_select_pin_out <= 1'b0;
    end else begin
      data_or_select_pin_out <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_byte_in;
    ok_c && st_r == I2C_RX && scl_fall && bcnt_r == BITS_PER_BYTE;
  endsequence

  sequence s_ack_start;
    s_byte_in ##0 (ph_r != PH_DEV);
  endsequence

  a_foreign_addr: assert property (s_byte_in ##0 (ph_r == PH_DEV && sh_r[7:1] != dev_r)
    |=> st_r == I2C_IDLE && !data_or_select_pin_oe_out)
    else $error("foreign bus address was answered");
  a_ack_drive: assert property (s_ack_start |=> data_or_select_pin_oe_out [*2])
    else $error("ack not held low");
  a_cfg_frozen: assert property (busy_c |=> $stable(proto_r) && $stable(asz_r)
    && $stable(dev_r))
    else $error("configuration changed inside a transaction");
  a_two_byte_off: assert property (i2c_set_r && proto_r == PROTO_I2C && asz_r == ASZ_2B
    |-> i2c_addr_r == {offh_r, sh_r})
    else $error("two-byte offset address wrong");
  a_smb_address: assert property (i2c_set_r && smb
    |-> i2c_addr_r[15:7] == page_r && i2c_addr_r[6:0] == sh_r[6:0])
    else $error("smbus address not page plus offset");
  a_ptr_advance: assert property (reg_wr_out || reg_rd_out
    |-> ptr_r == reg_addr_out + 16'h0001)
    else $error("pointer did not advance");
  a_page_write: assert property (rq_wr && page_hit
    |=> page_r[7:0] == $past(rq_wd) && !reg_wr_out)
    else $error("page register write lost");
  a_spi_page_addr: assert property (spi_set_r && asz_r == ASZ_1B
    |-> spi_addr_r[15:7] == page_r)
    else $error("spi one-byte address lacks page");
  a_blk_count: assert property (ok_c && st_r == I2C_ACK && scl_fall && rw_r && cntf_r
    |=> st_r == I2C_TX && sh_r == block_count_out)
    else $error("block read did not send count first");

endmodule : ssp_top

`default_nettype wire

/* File: shared/ssp_pkg.sv */
/*
  Constants, state and phase types for the serial slave register port.
  Assumes the host design supplies a byte-wide register file behind it.
*/
`default_nettype none

package ssp_pkg;

  // ==========================================================================
  // protocol selection and configuration reset values
  localparam logic [1:0] PROTO_I2C    = 2'h0;
  localparam logic [1:0] PROTO_SPI    = 2'h1;
  localparam logic [1:0] PROTO_SMB    = 2'h2;
  localparam logic [1:0] PROTO_RST    = PROTO_I2C;
  localparam logic       ASZ_1B       = 1'b0;
  localparam logic       ASZ_2B       = 1'b1;
  localparam logic       ASZ_RST      = ASZ_1B;
  localparam logic       BIDIR_RST    = 1'b0;
  localparam logic       CLK_SEL_RST  = 1'b0;
  localparam logic       DEL_OUT_RST  = 1'b0;
  localparam logic [6:0] DEV_ADDR_RST = 7'h09;
  localparam logic [7:0] BLK_CNT_RST  = 8'h08;
  localparam logic [8:0] PAGE_RST     = 9'h000;

  // ==========================================================================
  // address and framing layout
  localparam logic [7:0] PAGE_OFF      = 8'hFD;
  localparam int         SMB_BLK_BIT   = 7;
  localparam logic [4:0] SPI_HDR_1B    = 5'h08;
  localparam logic [4:0] SPI_HDR_2B    = 5'h10;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] DBIT_FIRST    = 3'h0;
  localparam logic [2:0] DBIT_LAST     = 3'h7;

  // ==========================================================================
  // state machines
  typedef enum logic [2:0] {I2C_IDLE, I2C_RX, I2C_ACK, I2C_TX, I2C_MACK} ssp_i2c_st_e;
  typedef enum logic [2:0] {PH_DEV, PH_OFFH, PH_OFFL, PH_CNT, PH_DATA} ssp_phase_e;

endpackage : ssp_pkg

`default_nettype wire

/* File: hw/ssp_sync.sv */
/*
  Two-flop synchroniser for a bundle of independent levels.
  Assumes each bit is a level or toggle that stays put for several clocks.
*/
`default_nettype none

module ssp_sync #(
  parameter int W = 3
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  // ==========================================================================
  // first stage feeds only the second stage
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule : ssp_sync

`default_nettype wire

/* File: dv/ssp_master.sv */
/*
  Bus master model for the serial slave register port: SPI and I2C/SMBus.
  Assumes the bench resolves the shared lines and selects the protocol.
*/
`default_nettype none

module ssp_master (
  output logic      sclk_out,
  output logic      sel_sda_out,
  output logic      sdio_out,
  output logic      sdio_en_out,
  input  wire logic sda_in,
  input  wire logic rd_line_in
);
  timeunit 1ns;
  timeprecision 1ps;

  int qt = 250;
  int         nrd = 0;
  logic       late = 1'b0;
  logic [7:0] rb [2];

  initial begin
    sclk_out    = 1'b0;
    sel_sda_out = 1'b1;
    sdio_out    = 1'b0;
    sdio_en_out = 1'b1;
  end

  // ==========================================================================
  // spi: clock runs only inside a frame
  task automatic sbit(input logic b, input int hi, output logic r);
    sdio_out = b;
    #3 r = rd_line_in;
    sclk_out = 1'b1;
    // a launch on the sampling edge is only caught just after that edge
    #3 if (late) r = rd_line_in;
    #(hi - 3) sclk_out = 1'b0;
    #3;
  endtask : sbit

  // long high phase on the last header bit gives the core time to fetch
  task automatic spi(input logic rw, input logic two, input logic [14:0] a,
                     input logic [15:0] wd, input int nb, output logic [15:0] rd);
    logic [15:0] h;
    logic        r;
    h = two ? {rw, a} : {rw, a[6:0], 8'h00};
    sclk_out = 1'b0;
    sel_sda_out = 1'b0;
    sdio_en_out = 1'b1;
    #20;
    for (int i = 15; i >= (two ? 0 : 8); i--) begin
      sbit(h[i], (rw && i == (two ? 0 : 8)) ? 100 : 6, r);
    end
    sdio_en_out = !rw;
    // bursts stay well inside the page
    for (int i = 15; i >= 16 - 8 * nb; i--) begin
      sbit(wd[i], 6, r);
      rd[i] = r;
    end
    #20 sel_sda_out = 1'b1;
    sdio_en_out = 1'b1;
    #60;
  endtask : spi

  // ==========================================================================
  // i2c / smbus
  task automatic ibit(input logic b, output logic r);
    sel_sda_out = b;
    #qt sclk_out = 1'b1;
    #qt r = sda_in;
    #qt sclk_out = 1'b0;
    #qt;
  endtask : ibit

  // block bursts are kept below offset 7f by the callers
  task automatic i2c(input logic [7:0] bs [$], output int acks);
    logic r;
    acks = 0;
    sclk_out = 1'b1;
    #qt sel_sda_out = 1'b0;
    #qt sclk_out = 1'b0;
    #qt;
    foreach (bs[k]) begin
      for (int i = 7; i >= 0; i--) begin
        ibit(bs[k][i], r);
      end
      ibit(1'b1, r);
      acks += int'(!r);
    end
    // repeated start, address with read bit, nrd bytes; the last one is not acked
    if (nrd > 0) begin
      sel_sda_out = 1'b1;
      #qt sclk_out = 1'b1;
      #qt sel_sda_out = 1'b0;
      #qt sclk_out = 1'b0;
      #qt;
      for (int i = 7; i >= 0; i--) begin
        ibit(bs[0][i] | (i == 0), r);
      end
      ibit(1'b1, r);
      acks += int'(!r);
      for (int k = 0; k < nrd; k++) begin
        for (int i = 7; i >= 0; i--) begin
          ibit(1'b1, r);
          rb[k][i] = r;
        end
        ibit(k == nrd - 1, r);
      end
    end
    sel_sda_out = 1'b0;
    #qt sclk_out = 1'b1;
    #qt sel_sda_out = 1'b1;
    #(4 * qt);
  endtask : i2c
endmodule : ssp_master

`default_nettype wire

/* File: dv/ssp_top_tb.sv */
/*
  Self-checking bench for the serial slave register port.
  Assumes the master model in ssp_master.sv; the register file is modelled here.
*/
`default_nettype none

module ssp_top_tb import ssp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_in, rst_in, sclk, sel_sda, m_d, m_en, two, bidir, csel, del;
  logic        dsp_out, dsp_oe, sil_out, sil_oe, sol_out, sol_oe, wr, rd, busy;
  logic        sda_w, sdio_w, rd_line;
  logic [1:0]  proto;
  logic [6:0]  dev, nd;
  logic [7:0]  wdat, rdat, bcnt;
  logic [7:0]  d [4];
  logic [8:0]  page;
  logic [15:0] ra, rv, e;
  logic [23:0] wq [$];
  int          seed = 6;
  int          miscompares, compares, acks;

  // open drain with pull-up; a released data line shows the inverse
  assign sda_w   = sel_sda & !dsp_oe;
  assign sdio_w  = sil_oe ? sil_out : (m_en ? m_d : !m_d);
  assign rd_line = bidir ? sdio_w : (sol_oe ? sol_out : !sol_out);

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = !clk_in;
  end

  // register file: read data valid one cycle after the strobe
  always @(posedge clk_in) begin
    if (rd) rdat <= ra[7:0] ^ 8'h5A;
    if (wr) wq.push_back({ra, wdat});
  end

  ssp_top i_ssp_top (.clk_in(clk_in), .rst_in(rst_in), .serial_clk_in(sclk),
    .data_or_select_pin_in(sda_w), .data_or_select_pin_out(dsp_out),
    .data_or_select_pin_oe_out(dsp_oe), .serial_in_line_in(sdio_w),
    .serial_in_line_out(sil_out), .serial_in_line_oe_out(sil_oe),
    .serial_out_line_out(sol_out), .serial_out_line_oe_out(sol_oe),
    .cfg_proto_in(proto), .cfg_addr_size_in(two), .cfg_bidir_line_mode_in(bidir),
    .cfg_clk_sel_in(csel), .cfg_del_out_in(del), .cfg_dev_addr_in(dev),
    .reg_addr_out(ra), .reg_wdata_out(wdat), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_rdata_in(rdat), .page_out(page), .block_count_out(bcnt), .busy_out(busy));

  ssp_master i_ssp_master (.sclk_out(sclk), .sel_sda_out(sel_sda), .sdio_out(m_d),
    .sdio_en_out(m_en), .sda_in(sda_w), .rd_line_in(rd_line));

  // ==========================================================================
  // checks and expectations
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_wr(input logic [15:0] a, input logic [7:0] dd);
    logic [23:0] g;
    g = (wq.size() > 0) ? wq.pop_front() : 24'hFFFFFF;
    chk_val(g[23:8], a);
    chk_val({8'h00, g[7:0]}, {8'h00, dd});
  endtask : chk_wr

  function automatic logic [15:0] ea(input int m, input logic [8:0] p, input logic [15:0] o);
    case (m)
      0: ea = {p[7:0], o[7:0]};
      1: ea = {p, o[6:0]};
      default: ea = {p[8], o[14:0]};
    endcase
  endfunction : ea

  // config only changes while the port is idle
  task automatic cfg(input logic [1:0] p, input logic t, input logic b, input logic c,
                     input logic l);
    @(posedge clk_in);
    #1 proto = p;
    del = l;
    two = t;
    bidir = b;
    csel = c;
    dev = nd;
    repeat (4) @(posedge clk_in);
  endtask : cfg

  task automatic end_sim();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    #800000;
    miscompares++;
    end_sim();
  end

  // ==========================================================================
  // scenarios
  initial begin
    {rst_in, proto, two, bidir} = {1'b1, PROTO_RST, ASZ_RST, BIDIR_RST};
    {csel, del, dev} = {CLK_SEL_RST, DEL_OUT_RST, DEV_ADDR_RST};
    foreach (d[i]) d[i] = 8'($random(seed));
    nd = 7'($random(seed));
    repeat (3) @(posedge clk_in);
    #1 rst_in = 1'b0;
    chk_val({7'h00, page}, {7'h00, PAGE_RST});
    chk_val({8'h00, bcnt}, {8'h00, BLK_CNT_RST});
    repeat (5) @(posedge clk_in);
    i_ssp_master.i2c('{8'h12, 8'h10, d[0]}, acks);
    chk_val(16'(acks), 16'h0003);
    chk_wr(ea(0, PAGE_RST, 16'h0010), d[0]);
    i_ssp_master.i2c('{8'h12, PAGE_OFF, 8'h01}, acks);
    chk_val({7'h00, page}, 16'h0001);
    i_ssp_master.i2c('{8'h14, 8'h20, d[1]}, acks);
    chk_val(16'(acks), 16'h0000);
    cfg(PROTO_I2C, ASZ_2B, BIDIR_RST, 1'b0, DEL_OUT_RST);
    i_ssp_master.i2c('{{nd, 1'b0}, 8'h02, 8'h34, d[1], d[2]}, acks);
    chk_wr(16'h0234, d[1]);
    chk_wr(16'h0235, d[2]);
    i_ssp_master.nrd = 2;
    i_ssp_master.i2c('{{nd, 1'b0}, 8'h02, 8'h34}, acks);
    i_ssp_master.nrd = 0;
    chk_val({8'h00, i_ssp_master.rb[0]}, {8'h00, 8'h34 ^ 8'h5A});
    chk_val({8'h00, i_ssp_master.rb[1]}, {8'h00, 8'h35 ^ 8'h5A});
    cfg(PROTO_SMB, ASZ_2B, BIDIR_RST, 1'b0, DEL_OUT_RST);
    i_ssp_master.qt = 2500;
    i_ssp_master.i2c('{{nd, 1'b0}, 8'h85, d[3]}, acks);
    i_ssp_master.qt = 250;
    chk_wr(ea(1, 9'h001, 16'h0005), d[3]);
    i_ssp_master.i2c('{{nd, 1'b0}, 8'h06, 8'h02, d[0], d[1]}, acks);
    chk_val({8'h00, bcnt}, 16'h0002);
    chk_wr(ea(1, 9'h001, 16'h0006), d[0]);
    chk_wr(ea(1, 9'h001, 16'h0007), d[1]);
    i_ssp_master.nrd = 2;
    i_ssp_master.i2c('{{nd, 1'b0}, 8'h10}, acks);
    i_ssp_master.nrd = 0;
    e = ea(1, 9'h001, 16'h0010);
    chk_val({8'h00, i_ssp_master.rb[0]}, 16'h0002);
    chk_val({8'h00, i_ssp_master.rb[1]}, {8'h00, e[7:0] ^ 8'h5A});
    for (int c = 0; c < 2; c++) begin
      cfg(PROTO_SPI, ASZ_1B, BIDIR_RST, c[0], DEL_OUT_RST);
      i_ssp_master.spi(1'b0, 1'b0, 15'h0011, {d[c], 8'h00}, 1, rv);
      chk_wr(ea(1, 9'h001, 16'h0011), d[c]);
    end
    cfg(PROTO_SPI, ASZ_2B, BIDIR_RST, 1'b0, DEL_OUT_RST);
    i_ssp_master.spi(1'b0, 1'b1, 15'h1234, {d[2], d[3]}, 2, rv);
    chk_wr(ea(2, 9'h001, 16'h1234), d[2]);
    chk_wr(ea(2, 9'h001, 16'h1235), d[3]);
    for (int b = 0; b < 3; b++) begin
      cfg(PROTO_SPI, ASZ_1B, b[0], 1'b0, b[1]);
      i_ssp_master.late = b[1];
      i_ssp_master.spi(1'b1, 1'b0, 15'h0042, 16'h0000, 2, rv);
      e = ea(1, 9'h001, 16'h0042);
      chk_val(rv, {e[7:0] ^ 8'h5A, (e[7:0] + 8'h01) ^ 8'h5A});
      chk_val({14'h0000, sol_oe, sil_oe}, 16'h0000);
    end
    chk_val(16'(wq.size()), 16'h0000);
    end_sim();
  end
endmodule : ssp_top_tb

`default_nettype wire
